/* rtl/ddr_command_timing_guard.sv */
`timescale 1ns/1ps
`include "ddr_guard_consts.svh"

module ddr_command_timing_guard (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire ddr_guard_pkg::cmd_t req_cmd,
    input wire logic [1:0] req_bank,
    output logic req_taken,
    output logic ddr_clk,
    output ddr_guard_pkg::cmd_t ddr_cmd,
    output logic [1:0] ddr_bank,
    output logic dqs_out,
    output logic dqs_oe,
    output logic refresh_due
);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    function automatic logic [3:0] step_down(input logic [3:0] v,
                                             input logic ld,
                                             input logic [3:0] lv);
        return ld ? lv : ((v != 4'h0) ? v - 4'h1 : 4'h0);
    endfunction

    logic [3:0] act_cnt [0:3];
    logic [3:0] ras_cnt [0:3];
    logic [3:0] rcd_cnt [0:3];
    logic [3:0] rrd_cnt;
    logic [3:0] gap_cnt;
    logic [3:0] wtr_cnt;
    logic [3:0] stb;
    logic [7:0] ref_cnt;
    logic status_pend;

    wire logic is_act = req_cmd == ddr_guard_pkg::CMD_ACTIVATE;
    wire logic is_pre = req_cmd == ddr_guard_pkg::CMD_PRECHARGE;
    wire logic is_rd = req_cmd == ddr_guard_pkg::CMD_READ;
    wire logic is_wra = req_cmd == ddr_guard_pkg::CMD_WRITE_AP;
    wire logic is_wr = is_wra || req_cmd == ddr_guard_pkg::CMD_WRITE;
    wire logic is_mrs = req_cmd == ddr_guard_pkg::CMD_MODE_SET;
    wire logic is_srq = req_cmd == ddr_guard_pkg::CMD_STATUS_REQ;
    wire logic is_ref = req_cmd == ddr_guard_pkg::CMD_REFRESH;
    wire logic is_pdx = req_cmd == ddr_guard_pkg::CMD_POWERDOWN_EXIT;

    logic [3:0] act_ok;
    logic [3:0] pre_ok;
    logic [3:0] acc_ok;

    // commands only leave while the link clock is high, so they change
    // on its falling edge and stand still across the sampling rise
    wire logic slot = ddr_clk;
    wire logic bank_rule_ok =
        (is_act && act_ok[req_bank] && rrd_cnt == 4'h0) ||
        (is_pre && pre_ok[req_bank]) ||
        (is_rd && acc_ok[req_bank] && wtr_cnt == 4'h0 &&
         stb == 4'h0) ||
        (is_wr && acc_ok[req_bank] && stb == 4'h0) ||
        !(is_act || is_pre || is_rd || is_wr);
    // refresh backlog lets through only what leads toward a refresh
    wire logic due_ok = !refresh_due || is_pre || is_ref || is_pdx;
    wire logic status_ok = !status_pend || is_rd;
    wire logic issue = slot && req_valid && gap_cnt == 4'h0 &&
        bank_rule_ok && due_ok && status_ok;

    wire logic [3:0] gap_load =
        is_mrs ? 4'(`MODE_SET_GAP_CYC) :
        is_srq ? 4'(`STATUS_REQ_GAP_CYC) :
        (is_rd && status_pend) ? 4'(`STATUS_READ_GAP_CYC) :
        is_ref ? 4'(`REFRESH_CYCLE_CYC) :
        is_pdx ? 4'(`POWERDOWN_EXIT_CYC) : 4'h0;

    wire logic [3:0] next_stb = (issue && is_wr) ? 4'h1 :
        (stb != 4'h0 && stb != 4'(`STROBE_END)) ? stb + 4'h1 : 4'h0;
    wire logic next_dqs_oe = next_stb >= 4'(`STROBE_OE_FIRST) &&
        next_stb <= 4'(`STROBE_OE_LAST);
    wire logic next_dqs_out = next_dqs_oe && !next_stb[0];
    wire logic ref_wrap = ref_cnt == 8'(`REFRESH_INTERVAL_CYC - 1);

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_bank
            wire logic hit = issue && req_bank == 2'(b);
            assign act_ok[b] = act_cnt[b] == 4'h0;
            assign pre_ok[b] = ras_cnt[b] == 4'h0;
            assign acc_ok[b] = rcd_cnt[b] == 4'h0;
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    act_cnt[b] <= 4'h0;
                    ras_cnt[b] <= 4'h0;
                    rcd_cnt[b] <= 4'h0;
                end else begin
                    act_cnt[b] <= step_down(act_cnt[b], hit && (is_act ||
                        is_wra), is_act ? 4'(`SAME_BANK_ACTIVATE_CYC) :
                        4'(`AUTOCLOSE_FROM_CMD_CYC));
                    ras_cnt[b] <= step_down(ras_cnt[b], hit && is_act,
                        4'(`OPEN_TO_CLOSE_CYC));
                    rcd_cnt[b] <= step_down(rcd_cnt[b], hit && is_act,
                        4'(`OPEN_TO_ACCESS_CYC));
                end
            end

            a_autoclose_gap: assert property (
                req_taken && ddr_cmd == ddr_guard_pkg::CMD_WRITE_AP &&
                ddr_bank == 2'(b) |=> !(req_taken && ddr_bank == 2'(b) &&
                ddr_cmd == ddr_guard_pkg::CMD_ACTIVATE) [*8])
                else $error("activate too soon after autoclose write");
            a_bank_activate: assert property (
                req_taken && ddr_cmd == ddr_guard_pkg::CMD_ACTIVATE &&
                ddr_bank == 2'(b) |=> !(req_taken && ddr_bank == 2'(b) &&
                ddr_cmd == ddr_guard_pkg::CMD_ACTIVATE) [*3])
                else $error("same bank activated twice too soon");
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ddr_clk <= 1'b0;
            ddr_cmd <= ddr_guard_pkg::CMD_NOP;
            ddr_bank <= 2'h0;
            req_taken <= 1'b0;
        end else begin
            ddr_clk <= !ddr_clk;
            req_taken <= issue;
            if (slot) begin
                ddr_cmd <= issue ? req_cmd : ddr_guard_pkg::CMD_NOP;
                ddr_bank <= issue ? req_bank : ddr_bank;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rrd_cnt <= 4'h0;
            gap_cnt <= 4'h0;
            wtr_cnt <= 4'h0;
            status_pend <= 1'b0;
        end else begin
            rrd_cnt <= step_down(rrd_cnt, issue && is_act,
                4'(`CROSS_BANK_ACTIVATE_CYC));
            gap_cnt <= step_down(gap_cnt, issue, gap_load);
            wtr_cnt <= step_down(wtr_cnt, issue && is_wr,
                4'(`WRITE_TO_READ_CYC));
            status_pend <= (issue && is_srq) ||
                (status_pend && !(issue && is_rd));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stb <= 4'h0;
            dqs_oe <= 1'b0;
            dqs_out <= 1'b0;
        end else begin
            stb <= next_stb;
            dqs_oe <= next_dqs_oe;
            dqs_out <= next_dqs_out;
        end
    end

    // a refresh issued in the wrap cycle still leaves the flag set
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_cnt <= 8'h00;
            refresh_due <= 1'b0;
        end else begin
            ref_cnt <= ref_wrap ? 8'h00 : ref_cnt + 8'h01;
            refresh_due <= ref_wrap ||
                (refresh_due && !(issue && is_ref));
        end
    end

    wire logic wr_taken = req_taken &&
        (ddr_cmd == ddr_guard_pkg::CMD_WRITE ||
         ddr_cmd == ddr_guard_pkg::CMD_WRITE_AP);

    sequence strobe_launch;
        !dqs_oe ##1 (dqs_oe && !dqs_out) ##1 (dqs_oe && dqs_out);
    endsequence
    sequence strobe_burst;
        !dqs_out ##1 dqs_out ##1 !dqs_out ##1 dqs_out
        ##1 (dqs_oe && !dqs_out) ##1 !dqs_oe;
    endsequence
    // commands a refresh backlog still lets through
    sequence refresh_path;
        ddr_cmd == ddr_guard_pkg::CMD_PRECHARGE ||
        ddr_cmd == ddr_guard_pkg::CMD_REFRESH ||
        ddr_cmd == ddr_guard_pkg::CMD_POWERDOWN_EXIT;
    endsequence

    a_strobe_launch: assert property (wr_taken |=> strobe_launch)
        else $error("first strobe rise not one clock after write");
    a_strobe_preamble: assert property (
        wr_taken |-> !dqs_oe ##2 strobe_burst)
        else $error("strobe preamble or burst out of place");
    a_strobe_phase: assert property (
        dqs_oe && $changed(dqs_out) |=> dqs_oe ##0 $changed(dqs_out) or
        !dqs_out)
        else $error("strobe phase longer than half a clock");
    a_strobe_fall: assert property (
        dqs_oe && $fell(dqs_out) |-> $fell(ddr_clk))
        else $error("strobe fall not centred between clock rises");
    a_mode_gap: assert property (
        req_taken && ddr_cmd == ddr_guard_pkg::CMD_MODE_SET
        |=> !req_taken [*3])
        else $error("command too soon after mode set");
    a_status_req: assert property (
        req_taken && ddr_cmd == ddr_guard_pkg::CMD_STATUS_REQ |=>
        !req_taken [*3] ##1 (!req_taken || ddr_cmd == ddr_guard_pkg::CMD_READ))
        else $error("status request not followed properly by read");
    a_status_read: assert property (
        req_taken && ddr_cmd == ddr_guard_pkg::CMD_READ &&
        $past(status_pend) |=> !req_taken [*7])
        else $error("command too soon after status read");
    a_powerdown_exit: assert property (
        req_taken && ddr_cmd == ddr_guard_pkg::CMD_POWERDOWN_EXIT
        |=> !req_taken [*3])
        else $error("command too soon after power-down exit");
    a_write_read: assert property (
        wr_taken |=> !(req_taken && ddr_cmd == ddr_guard_pkg::CMD_READ) [*7])
        else $error("read too soon after write data");
    a_refresh_flag: assert property (
        ref_wrap |=> refresh_due)
        else $error("refresh interval elapsed without flag");

    // judged on the flag as the issue decision saw it
    a_refresh_block: assert property (
        req_taken && $past(refresh_due) |-> refresh_path)
        else $error("command off the refresh path while refresh due");

    // a wrap in the same cycle keeps the flag, set wins
    a_refresh_clear: assert property (
        req_taken && ddr_cmd == ddr_guard_pkg::CMD_REFRESH &&
        !$past(ref_wrap) |-> !refresh_due)
        else $error("refresh flag not cleared by refresh");

    a_status_only: assert property (
        req_taken && $past(status_pend) |-> ddr_cmd == ddr_guard_pkg::CMD_READ)
        else $error("command other than read after status request");

    // command launched on the link clock fall, held across its rise
    a_launch_phase: assert property (
        req_taken |-> !ddr_clk ##1 (ddr_clk && ddr_cmd == $past(ddr_cmd)))
        else $error("command not stable across link clock rise");

    a_strobe_idle: assert property (
        !dqs_oe |-> !dqs_out)
        else $error("strobe high while not driven");

    // a second write may not cut the running strobe burst short
    a_write_spacing: assert property (
        wr_taken |=> !wr_taken [*7])
        else $error("write issued while strobe burst busy");

endmodule

/* rtl/ddr_guard_consts.svh */
`ifndef DDR_GUARD_CONSTS_SVH
`define DDR_GUARD_CONSTS_SVH

`define SYS_PERIOD_NS 50
`define TCK_CYC 2
`define TCK_NS (`SYS_PERIOD_NS * `TCK_CYC)
`define NS_UP(t) (((t) + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define TCK_UP(t) (((t) + `TCK_NS - 1) / `TCK_NS)

`define OPEN_TO_CLOSE_MIN_NS 40
`define SAME_BANK_ACTIVATE_GAP_NS 55
`define OPEN_TO_ACCESS_GAP_NS 15
`define CROSS_BANK_ACTIVATE_GAP_NS 12
`define WRITE_RECOVERY_GAP_NS 15
`define PRECHARGE_PERIOD_NS 15
`define REFRESH_CYCLE_NS 80
`define REFRESH_INTERVAL_NS 7800

`define MODE_SET_GAP_TCK 2
`define STATUS_REQUEST_TO_READ_GAP_TCK 2
`define READ_LATENCY_CYCLES 3
`define POWERDOWN_EXIT_GAP_TCK 1
`define WRITE_TO_READ_GAP_TCK 1
`define BURST_TCK 2

`define OPEN_TO_CLOSE_CYC `NS_UP(`OPEN_TO_CLOSE_MIN_NS)
`define SAME_BANK_ACTIVATE_CYC `NS_UP(`SAME_BANK_ACTIVATE_GAP_NS)
`define OPEN_TO_ACCESS_CYC `NS_UP(`OPEN_TO_ACCESS_GAP_NS)
`define CROSS_BANK_ACTIVATE_CYC `NS_UP(`CROSS_BANK_ACTIVATE_GAP_NS)
`define REFRESH_CYCLE_CYC `NS_UP(`REFRESH_CYCLE_NS)
`define REFRESH_INTERVAL_CYC (`REFRESH_INTERVAL_NS / `SYS_PERIOD_NS)
`define MODE_SET_GAP_CYC (`MODE_SET_GAP_TCK * `TCK_CYC)
`define STATUS_REQ_GAP_CYC (`STATUS_REQUEST_TO_READ_GAP_TCK * `TCK_CYC)
`define STATUS_READ_GAP_CYC ((`READ_LATENCY_CYCLES + 1) * `TCK_CYC)
`define POWERDOWN_EXIT_CYC (`POWERDOWN_EXIT_GAP_TCK * `TCK_CYC)
`define AUTOCLOSE_WRITE_GAP_TCK \
    (`TCK_UP(`WRITE_RECOVERY_GAP_NS) + `TCK_UP(`PRECHARGE_PERIOD_NS))
`define AUTOCLOSE_FROM_CMD_CYC \
    ((1 + `BURST_TCK + `AUTOCLOSE_WRITE_GAP_TCK) * `TCK_CYC)
`define WRITE_TO_READ_CYC \
    ((1 + `BURST_TCK + `WRITE_TO_READ_GAP_TCK) * `TCK_CYC)

`define STROBE_OE_FIRST 3
`define STROBE_OE_LAST 7
`define STROBE_END 8

`endif

/* rtl/ddr_guard_pkg.sv */
package ddr_guard_pkg;
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_PRECHARGE,
        CMD_READ,
        CMD_WRITE,
        CMD_WRITE_AP,
        CMD_MODE_SET,
        CMD_STATUS_REQ,
        CMD_REFRESH,
        CMD_POWERDOWN_EXIT
    } cmd_t;
endpackage

/* tb/ddr_dram_model.sv */
`timescale 1ns/1ps
module ddr_dram_model #(
    parameter int LAT = 3
) (
    input wire logic ddr_clk,
    input wire logic rst_b,
    input wire ddr_guard_pkg::cmd_t ddr_cmd,
    input wire logic [1:0] ddr_bank,
    input wire logic dqs_out,
    input wire logic dqs_oe,
    output int misuse
);
    realtime act[4];
    realtime now, any_act, prev_t, wr_t, clk_t, edge_t;
    ddr_guard_pkg::cmd_t c, prev;
    bit first, sr_rd, is_wr;
    initial misuse = 0;
    function automatic bit out_of(realtime d, realtime lo, realtime hi);
        return d < lo || d > hi;
    endfunction
    // gaps judged in ns, as the array sees them at the link clock rise
    always @(posedge ddr_clk or negedge rst_b) begin
        now = $realtime;
        clk_t = now;
        c = ddr_cmd;
        is_wr = c inside {ddr_guard_pkg::CMD_WRITE,
                          ddr_guard_pkg::CMD_WRITE_AP};
        if (!rst_b) begin
            act = '{default: -1.0e6};
            any_act = -1.0e6;
            wr_t = -1.0e6;
            prev = ddr_guard_pkg::CMD_NOP;
            sr_rd = 0;
        end else if (c != ddr_guard_pkg::CMD_NOP) begin
            if (prev == ddr_guard_pkg::CMD_MODE_SET)
                misuse += (now - prev_t < 200);
            if (prev == ddr_guard_pkg::CMD_POWERDOWN_EXIT)
                misuse += (now - prev_t < 100);
            if (prev == ddr_guard_pkg::CMD_STATUS_REQ)
                misuse += (c != ddr_guard_pkg::CMD_READ);
            if (prev == ddr_guard_pkg::CMD_STATUS_REQ)
                misuse += (now - prev_t < 200);
            if (sr_rd)
                misuse += (now - prev_t < (LAT + 1) * 100);
            sr_rd = (prev == ddr_guard_pkg::CMD_STATUS_REQ);
            if (c == ddr_guard_pkg::CMD_ACTIVATE) begin
                misuse += (now - act[ddr_bank] < 55);
                misuse += (now - any_act < 12);
                act[ddr_bank] = now;
                any_act = now;
            end
            if (c == ddr_guard_pkg::CMD_PRECHARGE)
                misuse += (now - act[ddr_bank] < 40);
            if (is_wr || c == ddr_guard_pkg::CMD_READ)
                misuse += (now - act[ddr_bank] < 15);
            if (is_wr) begin
                wr_t = now;
                first = 1;
            end
            prev = c;
            prev_t = now;
        end
    end
    always @(posedge dqs_oe)
        misuse += ($realtime < wr_t);
    always @(dqs_out) begin
        if (rst_b && dqs_oe) begin
            if (dqs_out && first)
                misuse += out_of($realtime - wr_t, 75, 125);
            else
                misuse += out_of($realtime - edge_t, 35, 60);
            if (!dqs_out)
                misuse += out_of($realtime - clk_t, 20, 80);
            first = 0;
            edge_t = $realtime;
        end
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int LINK = 2;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    ddr_guard_pkg::cmd_t req_cmd = ddr_guard_pkg::CMD_NOP;
    logic [1:0] req_bank = 2'h0;
    logic req_taken, ddr_clk, dqs_out, dqs_oe, refresh_due;
    ddr_guard_pkg::cmd_t ddr_cmd;
    logic [1:0] ddr_bank;
    int misuse, cyc = 0, bad_count = 0, comparisons = 0, due_t = 0;
    ddr_command_timing_guard dut_u (.sys_clk, .rst_b, .req_valid, .req_cmd,
        .req_bank, .req_taken, .ddr_clk, .ddr_cmd, .ddr_bank, .dqs_out,
        .dqs_oe, .refresh_due);
    ddr_dram_model dram_u (.ddr_clk, .rst_b, .ddr_cmd, .ddr_bank, .dqs_out,
        .dqs_oe, .misuse);
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_ge(input int got, input int lo);
        comparisons++;
        if (got < lo) begin
            bad_count++;
            $display("Error %0t: %0d below %0d", $time, got, lo);
        end
    endtask
    // ns to whole sys cycles, rounded up
    function automatic int cy(input int ns);
        return (ns + 49) / 50;
    endfunction
    // keeps valid up between chained sends so back to back slots are tried
    task automatic send(input ddr_guard_pkg::cmd_t c, input logic [1:0] b,
                        input bit first, input bit last, output int t);
        int n;
        n = 0;
        if (first)
            @(posedge sys_clk);
        req_cmd <= c;
        req_bank <= b;
        req_valid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_taken !== 1'b1 && n < 60);
        chk_bit(ddr_cmd === c && ddr_bank === b, 1'b1);
        if (last)
            req_valid <= 1'b0;
        t = cyc;
    endtask
    task automatic t_refresh();
        int n, t;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (refresh_due !== 1'b1 && n < 200);
        if (due_t > 0)
            chk_ge(7800 / 50, cyc - due_t);
        due_t = cyc;
        req_cmd <= ddr_guard_pkg::CMD_ACTIVATE;
        req_valid <= 1'b1;
        repeat (6) begin
            @(posedge sys_clk);
            chk_bit(req_taken, 1'b0);
        end
        send(ddr_guard_pkg::CMD_REFRESH, 2'h0, 0, 1, t);
        chk_bit(refresh_due, 1'b0);
    endtask
    task automatic t_bank();
        int t0, t1, t2, t3;
        send(ddr_guard_pkg::CMD_ACTIVATE, 2'h0, 1, 0, t0);
        send(ddr_guard_pkg::CMD_PRECHARGE, 2'h0, 0, 0, t1);
        send(ddr_guard_pkg::CMD_ACTIVATE, 2'h0, 0, 0, t2);
        send(ddr_guard_pkg::CMD_ACTIVATE, 2'h1, 0, 1, t3);
        chk_ge(t1 - t0, cy(40));
        chk_ge(t2 - t0, cy(55));
        chk_ge(t3 - t2, cy(12));
    endtask
    task automatic t_write();
        int t0, t1, t2, t3;
        logic [6:0] oe_w, out_w;
        oe_w = 7'h3E;
        out_w = 7'h14;
        send(ddr_guard_pkg::CMD_ACTIVATE, 2'h2, 1, 0, t0);
        send(ddr_guard_pkg::CMD_WRITE, 2'h2, 0, 1, t1);
        chk_ge(t1 - t0, cy(15));
        for (int k = 0; k < 7; k++) begin
            @(posedge sys_clk);
            chk_bit(dqs_oe, oe_w[k]);
            if (oe_w[k])
                chk_bit(dqs_out, out_w[k]);
        end
        send(ddr_guard_pkg::CMD_WRITE, 2'h2, 1, 0, t0);
        send(ddr_guard_pkg::CMD_READ, 2'h2, 0, 0, t1);
        send(ddr_guard_pkg::CMD_WRITE_AP, 2'h2, 0, 0, t2);
        send(ddr_guard_pkg::CMD_ACTIVATE, 2'h2, 0, 1, t3);
        chk_ge(t1 - t0, (1 + 2 + 1) * LINK);
        chk_ge(t3 - t2, (3 + 2 * ((15 + 99) / 100)) * LINK);
    endtask
    task automatic t_misc();
        int t0, t1, t2, t3, t4;
        send(ddr_guard_pkg::CMD_STATUS_REQ, 2'h0, 1, 0, t0);
        send(ddr_guard_pkg::CMD_READ, 2'h0, 0, 0, t1);
        send(ddr_guard_pkg::CMD_MODE_SET, 2'h0, 0, 0, t2);
        send(ddr_guard_pkg::CMD_POWERDOWN_EXIT, 2'h0, 0, 0, t3);
        send(ddr_guard_pkg::CMD_PRECHARGE, 2'h3, 0, 1, t4);
        chk_ge(t1 - t0, 2 * LINK);
        chk_ge(t2 - t1, (3 + 1) * LINK);
        chk_ge(t3 - t2, 2 * LINK);
        chk_ge(t4 - t3, 1 * LINK);
    endtask
    task automatic finish_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_refresh();
        t_bank();
        t_write();
        t_refresh();
        t_misc();
        chk_bit(misuse == 0, 1'b1);
        finish_test();
    end
endmodule
